/* File: core/ssic_fifo_mem.sv */
// Purpose: Small word store for the status FIFO
// Assumes: One write and one read port on one clock
// Notes: Read data is registered
`timescale 1ns/1ns
`default_nettype none
module ssic_fifo_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 12,
  parameter int AW = 4
) (
  input wire logic clk,
  input wire logic ce,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];
  initial begin
    if (DEPTH > (1 << AW)) $error("ssic_fifo_mem: AW too small");
  end
  always_ff @(posedge clk) begin
    if (ce && we) mem[waddr] <= wdata;
    if (ce) rdata <= mem[raddr];
  end
endmodule : ssic_fifo_mem
`default_nettype wire

/* File: core/ssic_map.svh */
// Purpose: Offsets, field positions and reset values for status strobe block
// Assumes: 4-bit register index written by the local microprocessor
// Notes: Definitions only
`ifndef SSIC_MAP_SVH
`define SSIC_MAP_SVH
`define SSIC_SECOND_CONTROL_IDX 4'he
`define SSIC_TRIG_BIT 0
`define SSIC_MODE_BIT 1
`define SSIC_FINISH_BIT 3
`define SSIC_BCKPOL_BIT 4
`define SSIC_CTRL_RESET 3'h0
`define SSIC_FIFO_DEPTH 12
`endif

/* File: core/ssic_pkg.sv */
// Purpose: Types shared by the status strobe block
// Assumes: Byte-wide status words
// Notes: Constants live in ssic_map.svh
package ssic_pkg;
  typedef struct packed {
    logic bckpol;
    logic finish;
    logic mode;
  } ssic_ctrl_s;
  typedef enum logic [2:0] {
    SSIC_IDLE = 3'h1,
    SSIC_RUN = 3'h2,
    SSIC_DRAIN = 3'h4
  } ssic_buf_e;
endpackage : ssic_pkg

/* File: core/ssic_status_strobe.sv */
// Purpose: Second control register, status FIFO and status-ready strobe
// Assumes: Microprocessor write strobe and host read strobe are one-cycle
//   pulses on clk; serial clock and sync arrive from pins
// Notes: Notes on behaviour follow
`timescale 1ns/1ns
`default_nettype none
`include "ssic_map.svh"
module ssic_status_strobe #(
  parameter int DEPTH = `SSIC_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic mp_wr,
  input wire logic [3:0] mp_addr,
  input wire logic [7:0] mp_wdata,
  input wire logic status_wr,
  input wire logic [7:0] status_wdata,
  input wire logic host_rd,
  output logic [7:0] host_rdata,
  output logic status_ready_n,
  input wire logic buffer_write_request,
  input wire logic sector_sync,
  output logic buffering,
  input wire logic serial_bit_clock,
  input wire logic serial_input_data,
  output logic serial_bit_valid,
  output logic serial_bit,
  output ssic_pkg::ssic_ctrl_s ctrl
);
  localparam int AW = $clog2(DEPTH + 1);
  initial begin
    if (DEPTH < 2) $error("ssic_status_strobe: DEPTH must be at least 2");
  end

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction : ptr_inc

  // Control register
  ssic_pkg::ssic_ctrl_s ctrl_q;
  logic trig_q;
  wire ctrl_hit = mp_wr && (mp_addr == `SSIC_SECOND_CONTROL_IDX);
  wire trig_write0 = ctrl_hit && !mp_wdata[`SSIC_TRIG_BIT];
  wire mode_next = ctrl_hit ? mp_wdata[`SSIC_MODE_BIT] : ctrl_q.mode;

  // FIFO bookkeeping
  logic [AW-1:0] wp_q, rp_q, cnt_q;
  logic ready_n_q;
  wire fifo_full = (cnt_q == AW'(DEPTH));
  wire fifo_empty = (cnt_q == '0);
  wire do_wr = status_wr && !fifo_full;
  wire do_rd = host_rd && !fifo_empty && !ready_n_q;
  wire last_rd = do_rd && (cnt_q == AW'(1)) && !do_wr;
  // Trigger in batch mode only, per-byte strobe otherwise
  wire fire_batch = trig_write0 && mode_next;
  wire fire_byte = do_wr && !ctrl_q.mode;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= `SSIC_CTRL_RESET;
      trig_q <= 1'b0;
    end else if (ce) begin
      if (ctrl_hit) begin
        ctrl_q.mode <= mp_wdata[`SSIC_MODE_BIT];
        ctrl_q.finish <= mp_wdata[`SSIC_FINISH_BIT];
        ctrl_q.bckpol <= mp_wdata[`SSIC_BCKPOL_BIT];
      end
      // Arming write wins over same-cycle last read
      if (fire_batch) trig_q <= 1'b1;
      else if (last_rd) trig_q <= 1'b0;
    end
  end
  assign ctrl = ctrl_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      ready_n_q <= 1'b1;
    end else if (ce) begin
      if (do_wr) wp_q <= ptr_inc(wp_q);
      if (do_rd) rp_q <= ptr_inc(rp_q);
      cnt_q <= cnt_q + AW'(do_wr) - AW'(do_rd);
      if (fire_byte || (fire_batch && (!fifo_empty || do_wr)))
        ready_n_q <= 1'b0;
      else if (last_rd) ready_n_q <= 1'b1;
    end
  end
  assign status_ready_n = ready_n_q;

  // Memory read address looks ahead so data is ready at the next read
  wire [AW-1:0] rd_addr = do_rd ? ptr_inc(rp_q) : rp_q;
  wire [AW-1:0] wr_addr = wp_q;
  logic [7:0] mem_rdata;
  ssic_fifo_mem #(.WIDTH(8), .DEPTH(DEPTH), .AW(AW)) u_mem (
    .clk(clk),
    .ce(ce),
    .we(do_wr),
    .waddr(wr_addr),
    .wdata(status_wdata),
    .raddr(rd_addr),
    .rdata(mem_rdata)
  );
  // Write to an empty store bypasses the one-cycle read latency
  logic bypass_q;
  logic [7:0] bypass_d_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bypass_q <= 1'b0;
      bypass_d_q <= 8'h00;
    end else if (ce) begin
      bypass_q <= do_wr && (wr_addr == rd_addr);
      bypass_d_q <= status_wdata;
    end
  end
  assign host_rdata = bypass_q ? bypass_d_q : mem_rdata;

  // Pin synchronisers: clock and sync changes count when stages two and three agree
  logic [2:0] sync_s_q, bck_s_q, dat_s_q;
  logic bck_q;
  logic sync_f_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync_s_q <= 3'h0;
      bck_s_q <= 3'h0;
      dat_s_q <= 3'h0;
      bck_q <= 1'b0;
      sync_f_q <= 1'b0;
    end else if (ce) begin
      sync_s_q <= {sync_s_q[1:0], sector_sync};
      bck_s_q <= {bck_s_q[1:0], serial_bit_clock};
      dat_s_q <= {dat_s_q[1:0], serial_input_data};
      if (bck_s_q[1] == bck_s_q[2]) bck_q <= bck_s_q[2];
      if (sync_s_q[1] == sync_s_q[2]) sync_f_q <= sync_s_q[2];
    end
  end
  // Polarity select flips the sampling edge of the filtered clock
  wire bck_eff = bck_q ^ ctrl_q.bckpol;
  wire bck_now = (bck_s_q[1] == bck_s_q[2]) ? bck_s_q[2] : bck_q;
  wire bck_now_eff = bck_now ^ ctrl_q.bckpol;
  wire sample = !bck_eff && bck_now_eff && ce;
  // Rise counts once stages two and three agree high
  wire sync_rise = (sync_s_q[2:1] == 2'b11) && !sync_f_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      serial_bit_valid <= 1'b0;
      serial_bit <= 1'b0;
    end else if (ce) begin
      serial_bit_valid <= sample;
      if (sample) serial_bit <= dat_s_q[2];
    end
  end

  // Buffering control
  ssic_pkg::ssic_buf_e st_q, st_d;
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ssic_pkg::SSIC_IDLE: if (buffer_write_request) st_d = ssic_pkg::SSIC_RUN;
      ssic_pkg::SSIC_RUN: begin
        if (!buffer_write_request)
          st_d = ctrl_q.finish ? ssic_pkg::SSIC_DRAIN : ssic_pkg::SSIC_IDLE;
      end
      ssic_pkg::SSIC_DRAIN: if (sync_rise) st_d = ssic_pkg::SSIC_IDLE;
      default: st_d = ssic_pkg::SSIC_IDLE;
    endcase
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) st_q <= ssic_pkg::SSIC_IDLE;
    else if (ce) st_q <= st_d;
  end
  assign buffering = (st_q != ssic_pkg::SSIC_IDLE);

  a_byte_strobe: assert property (@(posedge clk) disable iff (!resetn)
    ce && fire_byte |=> !status_ready_n) else $error("byte write no strobe");
  a_batch_quiet: assert property (@(posedge clk) disable iff (!resetn)
    ce && status_ready_n && ctrl.mode && !fire_batch |=> status_ready_n)
    else $error("batch mode strobe without trigger");
  a_trig_ignored: assert property (@(posedge clk) disable iff (!resetn)
    ce && trig_write0 && !mode_next && !do_wr && status_ready_n
    |=> status_ready_n) else $error("trigger acted in byte mode");
  a_trig_fires: assert property (@(posedge clk) disable iff (!resetn)
    ce && fire_batch && !fifo_empty |=> !status_ready_n && trig_q)
    else $error("trigger did not strobe");
  a_trig_clear: assert property (@(posedge clk) disable iff (!resetn)
    ce && last_rd && !fire_batch |=> !trig_q && status_ready_n)
    else $error("trigger not cleared on last read");
  a_reset_ctrl: assert property (@(posedge clk)
    $rose(resetn) |-> ctrl == 3'h0) else $error("control not reset");
  a_finish_hold: assert property (@(posedge clk) disable iff (!resetn)
    ce && st_q == ssic_pkg::SSIC_DRAIN && !sync_rise |=> buffering)
    else $error("buffering stopped before sync");
  a_pol_sample: assert property (@(posedge clk) disable iff (!resetn)
    sample |=> serial_bit_valid && serial_bit == $past(dat_s_q[2]))
    else $error("serial bit not captured");
  a_fifo_bound: assert property (@(posedge clk) disable iff (!resetn)
    cnt_q <= AW'(DEPTH)) else $error("fifo count overflow");
  a_ready_empty: assert property (@(posedge clk) disable iff (!resetn)
    !status_ready_n |-> !fifo_empty) else $error("ready with empty fifo");
endmodule : ssic_status_strobe
`default_nettype wire

/* File: dv/ssic_host_model.sv */
// Purpose: Host side that drains the status FIFO
// Assumes: Read strobe moves 1 ns after clk rises
// Notes: Bytes taken are kept in rx_q
`timescale 1ns/1ns
`default_nettype none
module ssic_host_model (
  input wire logic clk,
  input wire logic en,
  input wire logic status_ready_n,
  input wire logic [7:0] host_rdata,
  output logic host_rd
);
  logic [7:0] rx_q[$];
  logic go;
  initial host_rd = 1'b0;
  always @(posedge clk) begin
    if (host_rd) rx_q.push_back(host_rdata);
    // Sampled at the edge so the bench's own 1 ns drive cannot race
    go = en && !status_ready_n;
    #1;
    // Idle cycle between reads lets the head byte settle
    host_rd = !host_rd && go;
  end
endmodule : ssic_host_model
`default_nettype wire

/* File: dv/ssic_status_strobe_tb_top.sv */
// Purpose: Self-checking bench for the status strobe block
// Assumes: Inputs move 1 ns after clk rises
// Notes: Queue model of the FIFO; ce held high
`timescale 1ns/1ns
`default_nettype none
`include "ssic_map.svh"
module ssic_status_strobe_tb_top;
  logic clk, resetn, ce, mp_wr, status_wr, host_rd, en, d;
  logic [3:0] mp_addr;
  logic [7:0] mp_wdata, status_wdata, host_rdata;
  logic status_ready_n, buffer_write_request, sector_sync, buffering;
  logic serial_bit_clock, serial_input_data, serial_bit_valid, serial_bit;
  ssic_pkg::ssic_ctrl_s ctrl;
  logic [7:0] mq[$];
  int seed = 75;
  int n_fail = 0;
  int checks_done = 0;
  ssic_status_strobe dut (.clk, .resetn, .ce, .mp_wr, .mp_addr, .mp_wdata,
    .status_wr, .status_wdata, .host_rd, .host_rdata, .status_ready_n,
    .buffer_write_request, .sector_sync, .buffering, .serial_bit_clock,
    .serial_input_data, .serial_bit_valid, .serial_bit, .ctrl);
  ssic_host_model host (.clk, .en, .status_ready_n, .host_rdata, .host_rd);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic stop_test();
    if (n_fail == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t byte %h exp %h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t flag %b exp %b", $time, got, exp);
    end
  endtask : chk1
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    mp_wr = 1'b1;
    mp_addr = a;
    mp_wdata = v;
    tick();
    mp_wr = 1'b0;
    tick();
  endtask : wr_reg
  task automatic push(input logic [7:0] b);
    if (mq.size() < 12) mq.push_back(b);
    status_wr = 1'b1;
    status_wdata = b;
    tick();
    status_wr = 1'b0;
    tick();
  endtask : push
  task automatic drain();
    int i;
    en = 1'b1;
    for (i = 0; i < 80 && status_ready_n !== 1'b1; i++) tick();
    en = 1'b0;
    tick(2);
    chk8(8'(host.rx_q.size()), 8'(mq.size()));
    foreach (mq[j]) chk8(host.rx_q[j], mq[j]);
    chk1(status_ready_n, 1'b1);
    mq.delete();
    host.rx_q.delete();
  endtask : drain
  task automatic ser(input logic lv);
    int i;
    serial_bit_clock = lv;
    tick(8);
    serial_bit_clock = !lv;
    d = 1'($random(seed));
    serial_input_data = d;
    // The ignored edge must not produce a sample
    for (i = 0; i < 8; i++) begin
      tick();
      chk1(serial_bit_valid, 1'b0);
    end
    serial_bit_clock = lv;
    for (i = 0; i < 10 && serial_bit_valid !== 1'b1; i++) tick();
    chk1(serial_bit_valid, 1'b1);
    chk1(serial_bit, d);
  endtask : ser
  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    {mp_wr, status_wr, en, buffer_write_request, sector_sync} = '0;
    {serial_bit_clock, serial_input_data, mp_addr} = '0;
    {mp_wdata, status_wdata} = '0;
    tick(3);
    resetn = 1'b1;
    chk8({5'h0, ctrl}, 8'h00);
    chk1(status_ready_n, 1'b1);
    wr_reg(4'h3, 8'h1a);
    chk8({5'h0, ctrl}, 8'h00);
    push(8'($random(seed)));
    chk1(status_ready_n, 1'b0);
    repeat (12) push(8'($random(seed)));
    drain();
    wr_reg(`SSIC_SECOND_CONTROL_IDX, 8'h00);
    chk1(status_ready_n, 1'b1);
    wr_reg(`SSIC_SECOND_CONTROL_IDX, 8'h03);
    chk8({5'h0, ctrl}, 8'h01);
    repeat (3) push(8'($random(seed)));
    chk1(status_ready_n, 1'b1);
    wr_reg(`SSIC_SECOND_CONTROL_IDX, 8'h02);
    chk1(status_ready_n, 1'b0);
    drain();
    push(8'($random(seed)));
    tick(2);
    chk1(status_ready_n, 1'b1);
    wr_reg(`SSIC_SECOND_CONTROL_IDX, 8'h02);
    drain();
    wr_reg(`SSIC_SECOND_CONTROL_IDX, 8'h08);
    buffer_write_request = 1'b1;
    tick(2);
    chk1(buffering, 1'b1);
    buffer_write_request = 1'b0;
    tick(10);
    chk1(buffering, 1'b1);
    sector_sync = 1'b1;
    tick(8);
    chk1(buffering, 1'b0);
    sector_sync = 1'b0;
    wr_reg(`SSIC_SECOND_CONTROL_IDX, 8'h00);
    buffer_write_request = 1'b1;
    tick(2);
    buffer_write_request = 1'b0;
    tick(2);
    chk1(buffering, 1'b0);
    ser(1'b1);
    wr_reg(`SSIC_SECOND_CONTROL_IDX, 8'h10);
    ser(1'b0);
    stop_test();
  end
  initial begin
    #20000;
    n_fail++;
    stop_test();
  end
endmodule : ssic_status_strobe_tb_top
`default_nettype wire
